// File: bench/spicfg_assertions.sv
// checker: pin modes, abort on change, divider hold in wait
`timescale 1ns/1ps
module spicfg_assertions
    import spicfg_pkg::*;
(
    // clock, reset and apb
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [9:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0]  pstrb_i,
    input wire logic        pready_o,
    // system and pins
    input wire logic        wait_mode_i,
    input wire logic        force_idle_o,
    input wire logic        baud_tick_o,
    input wire logic        ss_oe_o,
    input wire logic        mosi_oe_o,
    input wire logic        miso_oe_o
);
    // ******
    // shadow configuration, updated at the taken edge
    // ******
    logic [1:0] c1_ff;
    logic [7:0] c2_ff;
    logic [7:0] dv_ff;
    logic       tk;
    logic       chg;
    assign tk = psel_i & penable_i & !pready_o & pwrite_i & pstrb_i[0];
    // boe counts as an abort field only while single-wire is on
    assign chg = c1_ff[0] && (tk && paddr_i == SPICFG_ADDR_CTRL2
        && |((pwdata_i[7:0] ^ c2_ff) & (c2_ff[0] ? 8'h19 : 8'h11))
        || tk && paddr_i == SPICFG_ADDR_DIVSEL
        && |((pwdata_i[7:0] ^ dv_ff) & 8'h77));
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            c1_ff <= 2'h0;
            c2_ff <= 8'h00;
            dv_ff <= 8'h00;
        end else if (tk) begin
            if (paddr_i == SPICFG_ADDR_CTRL1) c1_ff <= pwdata_i[1:0];
            if (paddr_i == SPICFG_ADDR_CTRL2) c2_ff <= pwdata_i[7:0];
            if (paddr_i == SPICFG_ADDR_DIVSEL) dv_ff <= pwdata_i[7:0];
        end
    end
    // ******
    // properties
    // ******
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_slave_ss_in: assert property (!c1_ff[0] |-> !ss_oe_o)
        else $error("select pin driven in slave mode");
    chk_master_ss: assert property (
        c1_ff[0] |-> ss_oe_o == (c2_ff[4] & c1_ff[1]))
        else $error("select pin drive wrong in master mode");
    chk_master_pins: assert property (
        c1_ff[0] |-> !miso_oe_o && mosi_oe_o == (!c2_ff[0] | c2_ff[3]))
        else $error("master data pin enables wrong");
    chk_slave_pins: assert property (
        !c1_ff[0] |-> !mosi_oe_o && miso_oe_o == (!c2_ff[0] | c2_ff[3]))
        else $error("slave data pin enables wrong");
    chk_bidir_oe: assert property (
        c2_ff[0] |-> (mosi_oe_o | miso_oe_o) == c2_ff[3])
        else $error("single-wire buffer does not follow enable");
    chk_abort_idle: assert property (
        chg |-> ##[1:2] force_idle_o)
        else $error("field change as master did not force idle");
    chk_wait_halt: assert property (
        (wait_mode_i && c2_ff[1]) [*3] |-> !baud_tick_o)
        else $error("serial clock ticks while halted in wait");
    chk_apb_answer: assert property (
        psel_i && $rose(penable_i) |=> pready_o ##1 !pready_o)
        else $error("register access not answered in one cycle");
    cover property (chg);
    cover property (ss_oe_o);
    cover property (c2_ff[0] && c1_ff[0] && mosi_oe_o);
endmodule // spicfg_assertions

bind spicfg_top spicfg_assertions u_chk (.*);

// File: bench/spicfg_partner.sv
// partner: far-side serial device and shared pin resolution
`timescale 1ns/1ps
module spicfg_partner (
    // clock and bench control
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic dev_mst_i,
    input  wire logic one_wire_i,
    input  wire logic bit_i,
    input  wire logic ss_low_i,
    // device pin drivers
    input  wire logic mosi_i,
    input  wire logic mosi_oe_i,
    input  wire logic miso_i,
    input  wire logic miso_oe_i,
    input  wire logic ss_i,
    input  wire logic ss_oe_i,
    // resolved pin levels
    output logic      mosi_pin_o,
    output logic      miso_pin_o,
    output logic      ss_pin_o
);
    logic tog_ff;
    logic on_mosi;
    // an undriven line toggles so a stale level cannot pass for data
    always_ff @(posedge clk_i) tog_ff <= rst_n_i ? ~tog_ff : 1'b0;
    // bits change only every few cycles, never at divide-by-two
    assign on_mosi = dev_mst_i ~^ one_wire_i;
    assign mosi_pin_o = mosi_oe_i ? mosi_i : (on_mosi ? bit_i : tog_ff);
    assign miso_pin_o = miso_oe_i ? miso_i : (on_mosi ? tog_ff : bit_i);
    // select line has a pull-up
    assign ss_pin_o = ss_oe_i ? ss_i : !ss_low_i;
endmodule // spicfg_partner

// File: bench/spicfg_tb_top.sv
// testbench: registers, pin modes, mode fault, divider and wait stop
`timescale 1ns/1ps
module spicfg_tb_top;
    import spicfg_pkg::*;
    logic        clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o;
    logic        pslverr_o, wait_mode_i, xfer_active_i, force_idle_o;
    logic        baud_tick_o, irq_o, ss_pin_i, ss_level_i, ss_o, ss_oe_o;
    logic        ss_in_o, mosi_pin_i, miso_pin_i, tx_bit_i, rx_bit_o;
    logic        mosi_o, mosi_oe_o, miso_o, miso_oe_o, mst, sws, bit_s;
    logic        ss_low, er, o;
    logic [9:0]  paddr_i;
    logic [3:0]  pstrb_i;
    logic [31:0] pwdata_i, prdata_o, rd, seed, d;
    logic [8:0]  ab [5] = '{9'h008, 9'h00A, 9'h10B, 9'h103, 9'h113};
    int          errors, comparisons, n, p, hits, ticks, h;
    spicfg_top u_dut (.*);
    spicfg_partner u_far (.clk_i(clk_i), .rst_n_i(rst_n_i), .dev_mst_i(mst),
        .one_wire_i(sws), .bit_i(bit_s), .ss_low_i(ss_low), .mosi_i(mosi_o),
        .mosi_oe_i(mosi_oe_o), .miso_i(miso_o), .miso_oe_i(miso_oe_o),
        .ss_i(ss_o), .ss_oe_i(ss_oe_o), .mosi_pin_o(mosi_pin_i),
        .miso_pin_o(miso_pin_i), .ss_pin_o(ss_pin_i));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        hits += (force_idle_o === 1'b1);
        ticks += (baud_tick_o === 1'b1);
    end
    // ******
    // helpers
    // ******
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] half(input logic [31:0] v);
        return ((32'(v[6:4]) + 32'h1) << (32'(v[2:0]) + 32'h1)) >> 1;
    endfunction
    task automatic chk(input string nm, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [9:0] a,
                       input logic [31:0] v);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= v;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        chk("pready wait", n, 32'h2);
    endtask
    task automatic cfg(input logic [7:0] c1, c2);
        apb(1'b1, SPICFG_ADDR_CTRL1, {24'h0, c1});
        apb(1'b1, SPICFG_ADDR_CTRL2, {24'h0, c2});
        mst <= c1[0];
        sws <= c2[0];
        repeat (5) @(posedge clk_i);
    endtask
    task automatic period();
        // let a stale tick from before the last write pass first
        repeat (2) @(posedge clk_i);
        for (n = 0; baud_tick_o !== 1'b1 && n < 3000; n++) @(posedge clk_i);
        p = 0;
        do begin
            @(posedge clk_i);
            p++;
        end while (baud_tick_o !== 1'b1 && p < 3000);
    endtask
    initial begin
        #2_400_000;
        errors++;
        print_verdict();
    end
    // ******
    // main sequence
    // ******
    initial begin
        {errors, comparisons, hits, ticks} = '0;
        seed = 32'h7D57;
        {rst_n_i, psel_i, penable_i, pwrite_i, wait_mode_i} = '0;
        {xfer_active_i, tx_bit_i, mst, sws, bit_s, ss_low} = '0;
        {paddr_i, pwdata_i} = '0;
        pstrb_i = 4'hF;
        ss_level_i = 1'b1;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        apb(1'b0, SPICFG_ADDR_DIVSEL, 32'h0);
        chk("divider reset", rd, {24'h0, SPICFG_DIVSEL_RST});
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            d = (i == 0) ? 32'hFFFFFFFF : seed;
            apb(1'b1, SPICFG_ADDR_DIVSEL, d);
            apb(1'b0, SPICFG_ADDR_DIVSEL, 32'h0);
            chk("divider select", rd, d & 32'h77);
            apb(1'b1, SPICFG_ADDR_CTRL2, d);
            apb(1'b0, SPICFG_ADDR_CTRL2, 32'h0);
            chk("control two", rd, d & 32'h1B);
        end
        apb(1'b0, 10'h3FC, 32'h0);
        chk("unmapped error", {31'h0, er}, 32'h1);
        pstrb_i <= 4'hE;
        apb(1'b1, SPICFG_ADDR_DIVSEL, ~d);
        pstrb_i <= 4'hF;
        apb(1'b0, SPICFG_ADDR_DIVSEL, 32'h0);
        chk("strobe off", rd, d & 32'h77);
        for (int m = 0; m < 32; m++) begin
            seed = lfsr(seed);
            bit_s <= seed[0];
            tx_bit_i <= seed[1];
            ss_level_i <= seed[2];
            cfg({6'h0, m[4], m[3]}, {3'h0, m[2], m[1], 2'h0, m[0]});
            // buffer off only in single-wire mode with output enable 0
            o = !(m[0] & !m[1]);
            rd = {30'h0, mosi_oe_o, miso_oe_o};
            d = {30'h0, m[3] & o, !m[3] & o};
            chk("data enables", rd, d);
            rd = {31'h0, ss_oe_o};
            d = {31'h0, m[3] & m[2] & m[4]};
            chk("select enable", rd, d);
            if (m[3] & m[2] & m[4]) begin
                chk("select out", 32'(ss_pin_i), 32'(ss_level_i));
            end
            // with the buffer on in single-wire mode the pin echoes our bit
            d = 32'((m[0] & m[1]) ? tx_bit_i : bit_s);
            chk("rx bit", 32'(rx_bit_o), d);
            if (o) begin
                rd = 32'(m[3] ? mosi_o : miso_o);
                chk("sent bit", rd, 32'(tx_bit_i));
            end
        end
        ss_level_i <= 1'b1;
        cfg(8'h01, 8'h00);
        apb(1'b1, SPICFG_ADDR_IRQMSK, 32'h0);
        apb(1'b1, SPICFG_ADDR_IRQST, 32'h1);
        ss_low <= 1'b1;
        repeat (8) @(posedge clk_i);
        apb(1'b0, SPICFG_ADDR_IRQST, 32'h0);
        chk("fault without detect", rd, 32'h0);
        ss_low <= 1'b0;
        cfg(8'h01, 8'h10);
        ss_low <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk("select input", {31'h0, ss_in_o}, 32'h0);
        chk("masked irq", {31'h0, irq_o}, 32'h0);
        apb(1'b0, SPICFG_ADDR_STAT, 32'h0);
        chk("fault flag", {31'h0, rd[0]}, 32'h1);
        apb(1'b1, SPICFG_ADDR_IRQMSK, 32'h1);
        chk("irq raised", {31'h0, irq_o}, 32'h1);
        ss_low <= 1'b0;
        repeat (8) @(posedge clk_i);
        apb(1'b1, SPICFG_ADDR_IRQST, 32'h1);
        chk("irq cleared", {31'h0, irq_o}, 32'h0);
        xfer_active_i <= 1'b1;
        cfg(8'h01, 8'h00);
        for (int i = 0; i < 5; i++) begin
            h = hits;
            apb(1'b1, SPICFG_ADDR_CTRL2, {23'h0, ab[i]});
            repeat (3) @(posedge clk_i);
            chk("abort", 32'(hits != h), 32'(ab[i][8]));
        end
        for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            d = (i == 0) ? 32'h0 : (i == 1) ? 32'h77 : seed & 32'h77;
            apb(1'b1, SPICFG_ADDR_DIVSEL, d);
            period();
            chk("half period", p, half(d));
        end
        apb(1'b1, SPICFG_ADDR_DIVSEL, 32'h0);
        apb(1'b1, SPICFG_ADDR_CTRL2, 32'h02);
        wait_mode_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        h = ticks;
        repeat (40) @(posedge clk_i);
        chk("halted ticks", ticks - h, 32'h0);
        apb(1'b1, SPICFG_ADDR_CTRL2, 32'h00);
        period();
        chk("wait ticks", p, 32'h1);
        print_verdict();
    end
endmodule // spicfg_tb_top

// File: include/spicfg_pkg.sv
// package: register map, field layout and types of the pin/baud block
package spicfg_pkg;

    // ************************************************************
    // register offsets (printed offsets are not all multiples of 4)
    // ************************************************************
    localparam logic [7:0] SPICFG_IDX_CTRL2  = 8'h01;
    localparam logic [7:0] SPICFG_IDX_DIVSEL = 8'h02;
    localparam logic [7:0] SPICFG_IDX_CTRL1  = 8'h00;
    localparam logic [7:0] SPICFG_IDX_STAT   = 8'h03;
    localparam logic [7:0] SPICFG_IDX_IRQST  = 8'h08;
    localparam logic [7:0] SPICFG_IDX_IRQMSK = 8'h09;
    localparam logic [9:0] SPICFG_ADDR_CTRL2  = {SPICFG_IDX_CTRL2, 2'b00};
    localparam logic [9:0] SPICFG_ADDR_DIVSEL = {SPICFG_IDX_DIVSEL, 2'b00};
    localparam logic [9:0] SPICFG_ADDR_CTRL1  = {SPICFG_IDX_CTRL1, 2'b00};
    localparam logic [9:0] SPICFG_ADDR_STAT   = {SPICFG_IDX_STAT, 2'b00};
    localparam logic [9:0] SPICFG_ADDR_IRQST  = {SPICFG_IDX_IRQST, 2'b00};
    localparam logic [9:0] SPICFG_ADDR_IRQMSK = {SPICFG_IDX_IRQMSK, 2'b00};

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int SPICFG_FDE_BIT  = 4;
    localparam int SPICFG_BOE_BIT  = 3;
    localparam int SPICFG_HIW_BIT  = 1;
    localparam int SPICFG_SWS_BIT  = 0;
    localparam int SPICFG_MST_BIT  = 0;
    localparam int SPICFG_SOE_BIT  = 1;
    localparam int SPICFG_MFF_BIT  = 0;
    localparam logic [7:0] SPICFG_CTRL2_MASK  = 8'h1B;
    localparam logic [7:0] SPICFG_DIVSEL_MASK = 8'h77;
    localparam logic [7:0] SPICFG_CTRL1_MASK  = 8'h03;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] SPICFG_CTRL2_RST  = 8'h00;
    localparam logic [7:0] SPICFG_DIVSEL_RST = 8'h00;
    localparam logic [7:0] SPICFG_CTRL1_RST  = 8'h00;

    typedef struct packed {
        logic fault_detect_enable;
        logic bidir_output_enable;
        logic halt_in_wait;
        logic single_wire_select;
    } spicfg_ctrl2_s;

    typedef struct packed {
        logic [2:0] prescale_select;
        logic [2:0] rate_shift_select;
    } spicfg_divsel_s;

    // pin driver bundle (level and output enable) for one two-way pin
    typedef struct packed {
        logic out;
        logic oe;
    } spicfg_pin_s;

endpackage

// File: rtl/spicfg_top.sv
// pin configuration, mode-fault detect and serial clock divider with APB
//
// Behaviour
// - master without fault detect ignores select pin
// - slave always takes select pin as input
// - master: field change other than halt-in-wait aborts transfer, forces idle
// - master: output-enable change aborts only single-wire
// - output enable steers MOSI master, MISO slave
// - output enable 0 disables, 1 enables buffer
// - halt-in-wait stops serial clock during wait
// - single-wire select: 0 two pins, 1 one
// - normal mode: master out MOSI, slave out MISO
// - master single-wire: MISO unused, MOSI data
// - slave single-wire: MOSI unused, MISO data
// - divisor is (prescale+1) times 2^(shift+1)
// - serial clock is bus clock over divisor
// - registers always accessible, reserved writes ignored
// - master with detect: select output or fault input
// - select low as master with detect and select output off sets fault
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module spicfg_top
    import spicfg_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [9:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // system
    input  wire logic        wait_mode_i,
    input  wire logic        xfer_active_i,
    output logic             force_idle_o,
    output logic             baud_tick_o,
    output logic             irq_o,
    // slave select pin
    input  wire logic        ss_pin_i,
    input  wire logic        ss_level_i,
    output logic             ss_o,
    output logic             ss_oe_o,
    output logic             ss_in_o,
    // data pins: core-side data and pin-side buffers
    input  wire logic        mosi_pin_i,
    input  wire logic        miso_pin_i,
    input  wire logic        tx_bit_i,
    output logic             rx_bit_o,
    output logic             mosi_o,
    output logic             mosi_oe_o,
    output logic             miso_o,
    output logic             miso_oe_o
);

    // ************************************************************
    // registers
    // ************************************************************
    spicfg_ctrl2_s  ctrl2_ff;
    spicfg_divsel_s divsel_ff;
    logic           master_select_ff;
    logic           select_output_enable_ff;
    logic           mode_fault_flag_ff;
    logic           irq_mask_ff;
    logic [7:0]     rdata_ff;
    logic           slverr_ff;
    logic           ready_ff;
    logic [2:0]     ss_sync_ff;
    logic           ss_filt_ff;
    logic [11:0]    div_cnt_ff;
    logic           tick_ff;
    logic           idle_ff;
    logic           rx_ff;
    logic [2:0]     mosi_sync_ff;
    logic [2:0]     miso_sync_ff;
    logic           tx_ff;
    logic           ss_drive_ff;

    logic           acc;
    logic           wr;
    logic           mapped;
    logic [7:0]     wbyte;
    spicfg_ctrl2_s  nxt_ctrl2;
    spicfg_divsel_s nxt_divsel;
    logic           nxt_master;
    logic           nxt_soe;
    logic           cfg_abort;
    logic           fault_in_use;
    logic           fault_event;
    logic [11:0]    divisor;
    logic [1:0]     rx_pair;

    // ************************************************************
    // apb decode
    // ************************************************************
    // one wait state: answer comes on the edge after the first access cycle
    assign acc    = psel_i && penable_i && !ready_ff;
    assign wr     = acc && pwrite_i && pstrb_i[0];
    assign wbyte  = pwdata_i[7:0];
    assign mapped = (paddr_i == SPICFG_ADDR_CTRL2)  ||
                    (paddr_i == SPICFG_ADDR_DIVSEL) ||
                    (paddr_i == SPICFG_ADDR_CTRL1)  ||
                    (paddr_i == SPICFG_ADDR_STAT)   ||
                    (paddr_i == SPICFG_ADDR_IRQST)  ||
                    (paddr_i == SPICFG_ADDR_IRQMSK);

    always_comb begin
        nxt_ctrl2  = ctrl2_ff;
        nxt_divsel = divsel_ff;
        nxt_master = master_select_ff;
        nxt_soe    = select_output_enable_ff;
        if (wr && paddr_i == SPICFG_ADDR_CTRL2) begin
            // reserved bit positions are simply not stored
            nxt_ctrl2.fault_detect_enable = wbyte[SPICFG_FDE_BIT];
            nxt_ctrl2.bidir_output_enable = wbyte[SPICFG_BOE_BIT];
            nxt_ctrl2.halt_in_wait        = wbyte[SPICFG_HIW_BIT];
            nxt_ctrl2.single_wire_select  = wbyte[SPICFG_SWS_BIT];
        end
        if (wr && paddr_i == SPICFG_ADDR_DIVSEL) begin
            nxt_divsel.prescale_select   = wbyte[6:4];
            nxt_divsel.rate_shift_select = wbyte[2:0];
        end
        if (wr && paddr_i == SPICFG_ADDR_CTRL1) begin
            nxt_master = wbyte[SPICFG_MST_BIT];
            nxt_soe    = wbyte[SPICFG_SOE_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl2_ff                <= spicfg_ctrl2_s'({
                SPICFG_CTRL2_RST[SPICFG_FDE_BIT],
                SPICFG_CTRL2_RST[SPICFG_BOE_BIT],
                SPICFG_CTRL2_RST[SPICFG_HIW_BIT],
                SPICFG_CTRL2_RST[SPICFG_SWS_BIT]});
            divsel_ff               <= spicfg_divsel_s'({
                SPICFG_DIVSEL_RST[6:4], SPICFG_DIVSEL_RST[2:0]});
            master_select_ff        <= SPICFG_CTRL1_RST[SPICFG_MST_BIT];
            select_output_enable_ff <= SPICFG_CTRL1_RST[SPICFG_SOE_BIT];
        end else begin
            ctrl2_ff                <= nxt_ctrl2;
            divsel_ff               <= nxt_divsel;
            master_select_ff        <= nxt_master;
            select_output_enable_ff <= nxt_soe;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ready_ff  <= 1'b0;
            slverr_ff <= 1'b0;
            rdata_ff  <= 8'h00;
        end else begin
            ready_ff  <= acc;
            slverr_ff <= acc && !mapped;
            rdata_ff  <= 8'h00;
            if (acc && !pwrite_i) begin
                case (paddr_i)
                    SPICFG_ADDR_CTRL2:  rdata_ff <= {3'h0,
                        ctrl2_ff.fault_detect_enable,
                        ctrl2_ff.bidir_output_enable, 1'b0,
                        ctrl2_ff.halt_in_wait,
                        ctrl2_ff.single_wire_select};
                    SPICFG_ADDR_DIVSEL: rdata_ff <= {1'b0,
                        divsel_ff.prescale_select, 1'b0,
                        divsel_ff.rate_shift_select};
                    SPICFG_ADDR_CTRL1:  rdata_ff <= {6'h00,
                        select_output_enable_ff, master_select_ff};
                    SPICFG_ADDR_STAT:   rdata_ff <= {5'h00, idle_ff,
                        ss_filt_ff, mode_fault_flag_ff};
                    SPICFG_ADDR_IRQST:  rdata_ff <= {7'h00,
                        mode_fault_flag_ff};
                    SPICFG_ADDR_IRQMSK: rdata_ff <= {7'h00, irq_mask_ff};
                    default:            rdata_ff <= 8'h00;
                endcase
            end
        end
    end

    assign pready_o  = ready_ff;
    assign pslverr_o = slverr_ff;
    assign prdata_o  = {24'h000000, rdata_ff};

    // ************************************************************
    // forced idle on configuration change
    // ************************************************************
    always_comb begin
        cfg_abort = 1'b0;
        if (master_select_ff) begin
            if (nxt_ctrl2.fault_detect_enable != ctrl2_ff.fault_detect_enable
                || nxt_ctrl2.single_wire_select
                   != ctrl2_ff.single_wire_select
                || nxt_divsel != divsel_ff
                || nxt_soe != select_output_enable_ff) begin
                cfg_abort = 1'b1;
            end
            if (ctrl2_ff.single_wire_select &&
                nxt_ctrl2.bidir_output_enable
                != ctrl2_ff.bidir_output_enable) begin
                cfg_abort = 1'b1;
            end
        end
        if (nxt_master != master_select_ff) begin
            cfg_abort = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            idle_ff <= 1'b1;
        end else begin
            idle_ff <= cfg_abort || fault_event || !xfer_active_i;
        end
    end

    assign force_idle_o = idle_ff;

    // ************************************************************
    // slave select pin and mode fault
    // ************************************************************
    // three stages: a change counts once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ss_sync_ff <= 3'h7;
            ss_filt_ff <= 1'b1;
        end else begin
            ss_sync_ff <= {ss_sync_ff[1:0], ss_pin_i};
            if (ss_sync_ff[2] == ss_sync_ff[1]) begin
                ss_filt_ff <= ss_sync_ff[2];
            end
        end
    end

    // fault input only for master, detect on, select output off
    assign fault_in_use = master_select_ff && ctrl2_ff.fault_detect_enable
                          && !select_output_enable_ff;
    assign fault_event  = fault_in_use && !ss_filt_ff;

    always_comb begin
        ss_o    = 1'b1;
        ss_oe_o = 1'b0;
        ss_in_o = 1'b1;
        if (!master_select_ff) begin
            ss_in_o = ss_filt_ff;
        end else if (ctrl2_ff.fault_detect_enable) begin
            ss_oe_o = select_output_enable_ff;
            ss_o    = ss_drive_ff;
            if (!select_output_enable_ff) begin
                ss_in_o = ss_filt_ff;
            end
        end
        // master without detect leaves pin released and unread
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mode_fault_flag_ff <= 1'b0;
        end else if (fault_event) begin
            mode_fault_flag_ff <= 1'b1;
        end else if (wr && paddr_i == SPICFG_ADDR_IRQST
                     && wbyte[SPICFG_MFF_BIT]) begin
            mode_fault_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_mask_ff <= 1'b0;
        end else if (wr && paddr_i == SPICFG_ADDR_IRQMSK) begin
            irq_mask_ff <= wbyte[SPICFG_MFF_BIT];
        end
    end

    assign irq_o = mode_fault_flag_ff && irq_mask_ff;

    // ************************************************************
    // data pin steering
    // ************************************************************
    // pin levels leave through flip-flops: one cycle later than the
    // core's bit, but free of decode glitches on the pads
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_ff       <= 1'b0;
            ss_drive_ff <= 1'b1;
        end else begin
            tx_ff       <= tx_bit_i;
            ss_drive_ff <= ss_level_i;
        end
    end

    always_comb begin
        mosi_o    = 1'b0;
        mosi_oe_o = 1'b0;
        miso_o    = 1'b0;
        miso_oe_o = 1'b0;
        if (master_select_ff) begin
            mosi_o = tx_ff;
            if (ctrl2_ff.single_wire_select) begin
                mosi_oe_o = ctrl2_ff.bidir_output_enable;
            end else begin
                mosi_oe_o = 1'b1;
            end
        end else begin
            miso_o = tx_ff;
            if (ctrl2_ff.single_wire_select) begin
                miso_oe_o = ctrl2_ff.bidir_output_enable;
            end else begin
                miso_oe_o = 1'b1;
            end
        end
    end

    // ************************************************************
    // data pin receive
    // ************************************************************
    // both data pins pass three stages; the receive bit moves only
    // once the last two stages agree, so a short glitch never lands
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mosi_sync_ff <= 3'h0;
            miso_sync_ff <= 3'h0;
        end else begin
            mosi_sync_ff <= {mosi_sync_ff[1:0], mosi_pin_i};
            miso_sync_ff <= {miso_sync_ff[1:0], miso_pin_i};
        end
    end

    // master single-wire and slave normal mode listen on mosi
    always_comb begin
        rx_pair = mosi_sync_ff[2:1];
        if (master_select_ff != ctrl2_ff.single_wire_select) begin
            rx_pair = miso_sync_ff[2:1];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rx_ff <= 1'b0;
        end else if (rx_pair[1] == rx_pair[0]) begin
            rx_ff <= rx_pair[1];
        end
    end

    assign rx_bit_o = rx_ff;

    // ************************************************************
    // baud divider
    // ************************************************************
    // tick marks each serial clock half period; divisor up to 2048
    assign divisor = 12'({9'h000, divsel_ff.prescale_select} + 12'h001)
                     << ({1'b0, divsel_ff.rate_shift_select} + 4'h1);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            div_cnt_ff <= 12'h000;
            tick_ff    <= 1'b0;
        end else if (idle_ff) begin
            div_cnt_ff <= 12'h000;
            tick_ff    <= 1'b0;
        end else if (wait_mode_i && ctrl2_ff.halt_in_wait) begin
            tick_ff    <= 1'b0;
        end else if (div_cnt_ff >= (divisor >> 1) - 12'h001) begin
            div_cnt_ff <= 12'h000;
            tick_ff    <= 1'b1;
        end else begin
            div_cnt_ff <= div_cnt_ff + 12'h001;
            tick_ff    <= 1'b0;
        end
    end

    assign baud_tick_o = tick_ff;

endmodule // spicfg_top
